/* urm_pkg.sv */
// Package with constants, field positions and types for the UART special line modes
package urm_pkg;

  // Feature control register
  localparam int FEATURE_CONTROL_REGISTER_HALF_DUPLEX_BIT = 3;
  // Setup/hysteresis register fields
  localparam int SHR_SETUP_HI         = 7;
  localparam int SHR_SETUP_LO         = 4;
  localparam int SHR_TURN_HI          = 3;
  localparam int SHR_TURN_LO          = 0;
  // Special function register
  localparam int SFR_ADDR_TX_BIT      = 7;
  localparam int SFR_MULTIDROP_BIT    = 6;
  localparam int SFR_IR_FAST_BIT      = 3;
  // Enhanced function register
  localparam int EFR_SPECIAL_CHAR_BIT = 5;
  localparam int EFR_ENHANCED_BIT     = 4;
  // Interrupt enable, modem control, FIFO control
  localparam int IER_SLEEP_BIT        = 4;
  localparam int MCR_IR_ENABLE_BIT    = 6;
  localparam int FCR_WAKE_INT_BIT     = 3;

  // Timing
  localparam int CLK_PERIOD_NS        = 10;
  localparam int SAMPLES_PER_BIT      = 16;
  localparam int IR_SLOW_SAMPLES      = 3;
  localparam int IR_FAST_SAMPLES      = 4;
  localparam int DELAY_W              = 4;

  // Serial frame
  localparam int DATA_W               = 8;
  localparam int FRAME_BITS           = 11;

  typedef enum logic [2:0] {
    URM_TX_IDLE,
    URM_TX_SETUP,
    URM_TX_SHIFT,
    URM_TX_TURN
  } urm_tx_state_t;

  typedef enum logic [1:0] {
    URM_PWR_RUN,
    URM_PWR_SLEEP
  } urm_pwr_state_t;

endpackage : urm_pkg

/* urm_buf2.sv */
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/10ps
module urm_buf2 #(
  parameter int WIDTH = 9
) (
  input  wire logic             mclk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);

  logic [WIDTH-1:0] mem_q [2];
  logic [WIDTH-1:0] mem_d [2];
  logic             rd_q, rd_d, wr_q, wr_d;
  logic [1:0]       cnt_q, cnt_d;
  logic             push, pop;

  assign in_ready  = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb
  begin
    mem_d = mem_q;
    rd_d  = rd_q;
    wr_d  = wr_q;
    cnt_d = cnt_q;
    if (push)
    begin
      mem_d[wr_q] = in_data;
      wr_d        = ~wr_q;
    end
    if (pop)
      rd_d = ~rd_q;
    if (push && !pop)
      cnt_d = cnt_q + 2'h1;
    else if (pop && !push)
      cnt_d = cnt_q - 2'h1;
  end

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      mem_q[0] <= '0;
      mem_q[1] <= '0;
      rd_q     <= 1'b0;
      wr_q     <= 1'b0;
      cnt_q    <= 2'h0;
    end
    else
    begin
      mem_q <= mem_d;
      rd_q  <= rd_d;
      wr_q  <= wr_d;
      cnt_q <= cnt_d;
    end
  end

endmodule : urm_buf2

/* urm_ir_codec.sv */
// Infrared pulse encoder and decoder
`timescale 1ns/10ps
module urm_ir_codec (
  input  wire logic mclk,
  input  wire logic reset_n,
  input  wire logic sample_tick,
  input  wire logic bit_start,
  input  wire logic ir_enable,
  input  wire logic ir_fast,
  input  wire logic tx_bit,
  input  wire logic rx_pin,
  output logic      tx_pin_d,
  output logic      rx_bit
);

  logic [4:0] phase_q, phase_d;
  logic [4:0] width;
  logic       rx_stretch_q, rx_stretch_d;
  logic [4:0] rx_cnt_q, rx_cnt_d;

  // Pulse width in sample ticks selects 3/16 or 1/4 of a bit
  assign width = ir_fast ? 5'(urm_pkg::IR_FAST_SAMPLES) : 5'(urm_pkg::IR_SLOW_SAMPLES);

  always_comb
  begin
    phase_d      = phase_q;
    rx_cnt_d     = rx_cnt_q;
    rx_stretch_d = rx_stretch_q;
    if (bit_start)
      phase_d = 5'h00;
    else if (sample_tick && phase_q != 5'h1F)
      phase_d = phase_q + 5'h01;
    // A light pulse on receive holds a zero for one bit time
    if (rx_pin)
    begin
      rx_stretch_d = 1'b1;
      rx_cnt_d     = 5'h00;
    end
    else if (sample_tick && rx_stretch_q)
    begin
      rx_cnt_d = rx_cnt_q + 5'h01;
      if (rx_cnt_q == 5'(urm_pkg::SAMPLES_PER_BIT - 1))
        rx_stretch_d = 1'b0;
    end
  end

  // One HIGH pulse for each zero bit; idle receive level is low
  assign tx_pin_d = ir_enable ? (!tx_bit && phase_q < width) : tx_bit;
  assign rx_bit   = ir_enable ? !rx_stretch_q : rx_pin;

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      phase_q      <= 5'h1F;
      rx_stretch_q <= 1'b0;
      rx_cnt_q     <= 5'h00;
    end
    else
    begin
      phase_q      <= phase_d;
      rx_stretch_q <= rx_stretch_d;
      rx_cnt_q     <= rx_cnt_d;
    end
  end

endmodule : urm_ir_codec

/* urm_line_modes.sv */
// UART special line modes: half-duplex direction, multidrop, infrared, sleep
`timescale 1ns/10ps
module urm_line_modes #(
  parameter logic [15:0] DIVISOR_DEFAULT = 16'h0001
) (
  input  wire logic       mclk,
  input  wire logic       reset_n,
  input  wire logic [7:0] feature_control_register,
  input  wire logic [7:0] setup_hysteresis_register,
  input  wire logic [7:0] special_function_register,
  input  wire logic       special_function_write,
  input  wire logic [7:0] enhanced_function_register,
  input  wire logic [7:0] modem_control_register,
  input  wire logic [7:0] interrupt_enable_register,
  input  wire logic [7:0] fifo_control_register,
  input  wire logic [7:0] second_stop_character_register,
  input  wire logic [15:0] divisor,
  input  wire logic       rts_request,
  input  wire logic [7:0] tx_wdata,
  input  wire logic       tx_write,
  output logic            tx_write_ready,
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  output logic            rx_parity_error,
  input  wire logic       rx_ready,
  input  wire logic       rx_fifo_empty,
  input  wire logic       tx_fifo_empty,
  input  wire logic       interrupt_pending,
  input  wire logic [3:0] modem_status_delta,
  input  wire logic [3:0] modem_inputs,
  input  wire logic       receiver_enable_set,
  input  wire logic       receiver_enable_clear,
  input  wire logic       wake_int_service,
  input  wire logic       sleep_pin,
  input  wire logic       rx_pin,
  output logic            tx_pin,
  output logic            rts_pin,
  output logic            tx_empty_event,
  output logic            line_status_event,
  output logic            receiver_enabled,
  output logic            wake_int_flag,
  output logic            osc_stopped
);

  localparam int SPB = urm_pkg::SAMPLES_PER_BIT;

  ////////////////////////////////////////////////////////////////
  // Mode decode
  logic half_duplex, enh, multidrop, auto_addr, ir_en, ir_fast;
  assign half_duplex = feature_control_register[urm_pkg::FEATURE_CONTROL_REGISTER_HALF_DUPLEX_BIT];
  assign enh         = enhanced_function_register[urm_pkg::EFR_ENHANCED_BIT];
  assign multidrop   = enh && special_function_register[urm_pkg::SFR_MULTIDROP_BIT];
  assign auto_addr   = multidrop && enhanced_function_register[urm_pkg::EFR_SPECIAL_CHAR_BIT];
  assign ir_en       = modem_control_register[urm_pkg::MCR_IR_ENABLE_BIT];
  assign ir_fast     = ir_en && enh && special_function_register[urm_pkg::SFR_IR_FAST_BIT];

  ////////////////////////////////////////////////////////////////
  // Sample tick: divisor clocks per sixteenth of a bit
  logic [15:0] div_cnt_q, div_cnt_d;
  logic        tick;
  logic        asleep;
  assign tick = (div_cnt_q == 16'h0001) && !asleep;

  always_comb
  begin
    div_cnt_d = div_cnt_q;
    if (asleep || div_cnt_q <= 16'h0001)
      div_cnt_d = (divisor == 16'h0000) ? DIVISOR_DEFAULT : divisor;
    else
      div_cnt_d = div_cnt_q - 16'h0001;
  end

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
      div_cnt_q <= 16'h0001;
    else
      div_cnt_q <= div_cnt_d;
  end

  ////////////////////////////////////////////////////////////////
  // Transmit path: address marker joins each byte in the buffer
  logic       addr_mark_q, addr_mark_d;
  logic [8:0] tb_data;
  logic       tb_valid, tb_ready;

  urm_buf2 #(.WIDTH(9)) u_txbuf (
    .mclk      (mclk),
    .reset_n   (reset_n),
    .in_data   ({addr_mark_q, tx_wdata}),
    .in_valid  (tx_write),
    .in_ready  (tx_write_ready),
    .out_data  (tb_data),
    .out_valid (tb_valid),
    .out_ready (tb_ready)
  );

  always_comb
  begin
    addr_mark_d = addr_mark_q;
    if (special_function_write && special_function_register[urm_pkg::SFR_ADDR_TX_BIT])
      addr_mark_d = 1'b1;
    else if (tx_write && tx_write_ready)
      addr_mark_d = 1'b0;
  end

  // Transmitter with direction control
  urm_pkg::urm_tx_state_t tx_st_q, tx_st_d;
  logic [10:0] shf_q, shf_d;
  logic [3:0]  bitn_q, bitn_d;
  logic [4:0]  smp_q, smp_d;
  logic [3:0]  dly_q, dly_d;
  logic        bit_start, bit_end, rts_d, tx_bit, tx_pin_d, txe_d, rx_bit;

  assign bit_end   = tick && smp_q == 5'(SPB - 1);
  assign tb_ready  = (tx_st_q == urm_pkg::URM_TX_IDLE) && !sleep_pin;

  always_comb
  begin
    tx_st_d   = tx_st_q;
    shf_d     = shf_q;
    bitn_d    = bitn_q;
    dly_d     = dly_q;
    smp_d     = tick ? ((smp_q == 5'(SPB - 1)) ? 5'h00 : smp_q + 5'h01) : smp_q;
    bit_start = 1'b0;
    txe_d     = 1'b0;
    case (tx_st_q)
      urm_pkg::URM_TX_IDLE:
        if (tb_valid && !sleep_pin)
        begin
          // Ninth bit carries the address marker in the parity slot
          shf_d   = {1'b1, tb_data[8], tb_data[7:0], 1'b0};
          smp_d   = 5'h00;
          dly_d   = setup_hysteresis_register[urm_pkg::SHR_SETUP_HI:urm_pkg::SHR_SETUP_LO];
          tx_st_d = (half_duplex && dly_d != 4'h0) ? urm_pkg::URM_TX_SETUP : urm_pkg::URM_TX_SHIFT;
          bitn_d  = 4'h0;
          bit_start = (tx_st_d == urm_pkg::URM_TX_SHIFT);
        end
      urm_pkg::URM_TX_SETUP:
        if (bit_end)
        begin
          dly_d = dly_q - 4'h1;
          if (dly_q == 4'h1)
          begin
            tx_st_d   = urm_pkg::URM_TX_SHIFT;
            bit_start = 1'b1;
          end
        end
      urm_pkg::URM_TX_SHIFT:
        if (bit_end)
        begin
          bit_start = 1'b1;
          shf_d     = {1'b1, shf_q[10:1]};
          bitn_d    = bitn_q + 4'h1;
          if (bitn_q == 4'(urm_pkg::FRAME_BITS - 1))
          begin
            bit_start = 1'b0;
            txe_d     = !(tb_valid && !sleep_pin);
            dly_d     = setup_hysteresis_register[urm_pkg::SHR_TURN_HI:urm_pkg::SHR_TURN_LO];
            if (tb_valid && !sleep_pin)
              tx_st_d = urm_pkg::URM_TX_IDLE;
            else if (half_duplex && dly_d != 4'h0)
              tx_st_d = urm_pkg::URM_TX_TURN;
            else
              tx_st_d = urm_pkg::URM_TX_IDLE;
          end
        end
      urm_pkg::URM_TX_TURN:
        if (tb_valid && !sleep_pin)
          tx_st_d = urm_pkg::URM_TX_IDLE;
        else if (bit_end)
        begin
          dly_d = dly_q - 4'h1;
          if (dly_q == 4'h1)
            tx_st_d = urm_pkg::URM_TX_IDLE;
        end
      default:
        tx_st_d = urm_pkg::URM_TX_IDLE;
    endcase
    tx_bit = (tx_st_q == urm_pkg::URM_TX_SHIFT) ? shf_q[0] : 1'b1;
    // Direction high while data is buffered or on the line
    if (half_duplex)
      rts_d = tb_valid || (tx_write && tx_write_ready) || (tx_st_d != urm_pkg::URM_TX_IDLE);
    else
      rts_d = rts_request;
  end

  urm_ir_codec u_ir (
    .mclk        (mclk),
    .reset_n     (reset_n),
    .sample_tick (tick),
    .bit_start   (bit_start),
    .ir_enable   (ir_en),
    .ir_fast     (ir_fast),
    .tx_bit      (tx_bit),
    .rx_pin      (rx_pin),
    .tx_pin_d    (tx_pin_d),
    .rx_bit      (rx_bit)
  );

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      tx_st_q        <= urm_pkg::URM_TX_IDLE;
      shf_q          <= '1;
      bitn_q         <= 4'h0;
      smp_q          <= 5'h00;
      dly_q          <= 4'h0;
      addr_mark_q    <= 1'b0;
      tx_pin         <= 1'b1;
      rts_pin        <= 1'b0;
      tx_empty_event <= 1'b0;
    end
    else
    begin
      tx_st_q        <= tx_st_d;
      shf_q          <= shf_d;
      bitn_q         <= bitn_d;
      smp_q          <= smp_d;
      dly_q          <= dly_d;
      addr_mark_q    <= addr_mark_d;
      tx_pin         <= tx_pin_d;
      rts_pin        <= rts_d;
      // Shift-register empty in half-duplex, holding empty otherwise
      tx_empty_event <= half_duplex ? txe_d : (tb_valid && tb_ready && !tx_write);
    end
  end

  ////////////////////////////////////////////////////////////////
  // Receiver with multidrop filtering
  logic [9:0] rsh_q, rsh_d;
  logic [3:0] rbit_q, rbit_d;
  logic [4:0] rsmp_q, rsmp_d;
  logic       rbusy_q, rbusy_d, rprev_q, ren_q, ren_d;
  logic       rv_d, rpe_d, lse_d, rx_start_edge;
  logic [7:0] rd_d;
  logic       frame_done;

  assign rx_start_edge = rprev_q && !rx_bit && !rbusy_q;
  assign frame_done    = rbusy_q && tick && rsmp_q == 5'(SPB - 1) && rbit_q == 4'(urm_pkg::FRAME_BITS - 2);

  always_comb
  begin
    rsh_d   = rsh_q;
    rbit_d  = rbit_q;
    rsmp_d  = rsmp_q;
    rbusy_d = rbusy_q;
    ren_d   = ren_q;
    rv_d    = 1'b0;
    rpe_d   = 1'b0;
    rd_d    = rsh_q[8:1];
    lse_d   = 1'b0;
    if (rx_start_edge && !sleep_pin)
    begin
      rbusy_d = 1'b1;
      rbit_d  = 4'h0;
      rsmp_d  = 5'(SPB / 2);
    end
    else if (rbusy_q && tick)
    begin
      rsmp_d = rsmp_q + 5'h01;
      if (rsmp_q == 5'(SPB - 1))
      begin
        rsmp_d = 5'h00;
        rsh_d  = {rx_bit, rsh_q[9:1]};
        rbit_d = rbit_q + 4'h1;
      end
    end
    if (frame_done)
    begin
      rbusy_d = 1'b0;
      rd_d    = rsh_d[8:1];
      if (!multidrop)
        rv_d = 1'b1;
      else if (auto_addr)
      begin
        if (rsh_d[9] && rsh_d[8:1] == second_stop_character_register)
        begin
          ren_d = 1'b1;
          rv_d  = 1'b1;
          rpe_d = 1'b1;
          lse_d = 1'b1;
        end
        else if (rsh_d[9])
          ren_d = 1'b0;
        else
          rv_d = ren_q;
      end
      else
      begin
        // Address bytes always stored and reported; data only when enabled
        rv_d  = rsh_d[9] || ren_q;
        rpe_d = rsh_d[9];
        lse_d = rsh_d[9];
      end
    end
    if (!auto_addr)
    begin
      if (receiver_enable_set)
        ren_d = 1'b1;
      else if (receiver_enable_clear)
        ren_d = 1'b0;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      rsh_q             <= '0;
      rbit_q            <= 4'h0;
      rsmp_q            <= 5'h00;
      rbusy_q           <= 1'b0;
      rprev_q           <= 1'b1;
      ren_q             <= 1'b0;
      rx_valid          <= 1'b0;
      rx_data           <= 8'h00;
      rx_parity_error   <= 1'b0;
      line_status_event <= 1'b0;
      receiver_enabled  <= 1'b0;
    end
    else
    begin
      rsh_q             <= rsh_d;
      rbit_q            <= rbit_d;
      rsmp_q            <= rsmp_d;
      rbusy_q           <= rbusy_d;
      rprev_q           <= rx_bit;
      ren_q             <= ren_d;
      rx_valid          <= rv_d || (rx_valid && !rx_ready);
      rx_data           <= rv_d ? rd_d : rx_data;
      rx_parity_error   <= rv_d ? rpe_d : rx_parity_error;
      line_status_event <= lse_d;
      receiver_enabled  <= ren_d;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Sleep control and wake-up flag
  urm_pkg::urm_pwr_state_t pwr_q, pwr_d;
  logic       reg_sleep_ok, pin_sleep_ok, wake_ev, wake_d;
  logic [3:0] mdm_prev_q;
  assign asleep = (pwr_q == urm_pkg::URM_PWR_SLEEP);

  assign reg_sleep_ok = !interrupt_pending && interrupt_enable_register[urm_pkg::IER_SLEEP_BIT]
                        && modem_status_delta == 4'h0 && !rbusy_q && (rx_pin == !ir_en)
                        && divisor != 16'h0000 && tx_fifo_empty && rx_fifo_empty
                        && !tb_valid && tx_st_q == urm_pkg::URM_TX_IDLE;
  assign pin_sleep_ok = sleep_pin && !rbusy_q && tx_st_q == urm_pkg::URM_TX_IDLE;
  assign wake_ev      = rx_start_edge || tx_write || (modem_inputs != mdm_prev_q);

  always_comb
  begin
    pwr_d  = pwr_q;
    wake_d = wake_int_flag;
    case (pwr_q)
      urm_pkg::URM_PWR_RUN:
        if (pin_sleep_ok || (reg_sleep_ok && !sleep_pin))
          pwr_d = urm_pkg::URM_PWR_SLEEP;
      urm_pkg::URM_PWR_SLEEP:
        // Pin sleep ends only on release; register sleep ends on any wake source
        if (sleep_pin ? 1'b0 : (wake_ev || !interrupt_enable_register[urm_pkg::IER_SLEEP_BIT]
                                || !reg_sleep_ok))
          pwr_d = urm_pkg::URM_PWR_RUN;
      default:
        pwr_d = urm_pkg::URM_PWR_RUN;
    endcase
    if (wake_int_service)
      wake_d = 1'b0;
    if (asleep && pwr_d == urm_pkg::URM_PWR_RUN && fifo_control_register[urm_pkg::FCR_WAKE_INT_BIT])
      wake_d = 1'b1;
  end

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      pwr_q         <= urm_pkg::URM_PWR_RUN;
      mdm_prev_q    <= 4'h0;
      wake_int_flag <= 1'b0;
      osc_stopped   <= 1'b0;
    end
    else
    begin
      pwr_q         <= pwr_d;
      mdm_prev_q    <= modem_inputs;
      wake_int_flag <= wake_d;
      osc_stopped   <= (pwr_d == urm_pkg::URM_PWR_SLEEP);
    end
  end

endmodule : urm_line_modes

/* urm_line_modes_assertions.sv */
// Concurrent checks on the ports of the UART special line modes block
`timescale 1ns/10ps
module urm_chk (
  input wire logic        mclk,
  input wire logic        reset_n,
  input wire logic [7:0]  feature_control_register,
  input wire logic [7:0]  special_function_register,
  input wire logic [7:0]  enhanced_function_register,
  input wire logic [7:0]  interrupt_enable_register,
  input wire logic [7:0]  fifo_control_register,
  input wire logic [7:0]  second_stop_character_register,
  input wire logic [15:0] divisor,
  input wire logic        tx_write,
  input wire logic        tx_write_ready,
  input wire logic        rx_valid,
  input wire logic [7:0]  rx_data,
  input wire logic        rx_parity_error,
  input wire logic        rx_ready,
  input wire logic        rx_fifo_empty,
  input wire logic        tx_fifo_empty,
  input wire logic        interrupt_pending,
  input wire logic [3:0]  modem_status_delta,
  input wire logic        sleep_pin,
  input wire logic        tx_pin,
  input wire logic        rts_pin,
  input wire logic        line_status_event,
  input wire logic        receiver_enabled,
  input wire logic        wake_int_flag,
  input wire logic        osc_stopped
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  sequence s_take;
    tx_write && tx_write_ready;
  endsequence
  sequence s_enter;
    $rose(osc_stopped) && !sleep_pin;
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  rts_rise_a: assert property (
    s_take ##0 (feature_control_register[3] && !sleep_pin && !osc_stopped) |=> rts_pin)
    else $error("direction output missed a transmit write");
  data_dir_a: assert property (feature_control_register[3] && !tx_pin |-> rts_pin)
    else $error("transmit data without direction output");
  sleep_cond_a: assert property (s_enter |-> $past(interrupt_enable_register[4] && !interrupt_pending
    && modem_status_delta == 4'h0 && divisor != 16'h0000 && rx_fifo_empty && tx_fifo_empty))
    else $error("sleep entered with a wake condition present");
  pin_hold_a: assert property (sleep_pin && osc_stopped |=> osc_stopped)
    else $error("woke while the sleep pin is held");
  wake_flag_a: assert property ($fell(osc_stopped) && fifo_control_register[3] |-> ##[0:2] wake_int_flag)
    else $error("wake-up flag missing after leaving sleep");
  rx_hold_a: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_data))
    else $error("receive word lost during a stall");
  addr_flag_a: assert property (
    line_status_event && special_function_register[6] |-> rx_valid && rx_parity_error)
    else $error("line-status event without a stored address byte");
  auto_match_a: assert property ($rose(receiver_enabled) && !$past(rx_valid)
    && special_function_register[6] && enhanced_function_register[5]
    |-> ##[0:1] (rx_valid && rx_parity_error && rx_data == second_stop_character_register))
    else $error("auto address enable without the matching byte");
endmodule : urm_chk

bind urm_line_modes urm_chk u_chk (.mclk, .reset_n, .feature_control_register, .special_function_register,
  .enhanced_function_register, .interrupt_enable_register, .fifo_control_register,
  .second_stop_character_register, .divisor, .tx_write, .tx_write_ready, .rx_valid, .rx_data,
  .rx_parity_error, .rx_ready, .rx_fifo_empty, .tx_fifo_empty, .interrupt_pending, .modem_status_delta,
  .sleep_pin, .tx_pin, .rts_pin, .line_status_event, .receiver_enabled, .wake_int_flag, .osc_stopped);

/* urm_xcvr.sv */
// RS-485 transceiver model with a remote station sending on the bus
`timescale 1ns/10ps
module urm_xcvr (
  input  wire logic mclk,
  input  wire logic de,
  output logic      rx_pin
);
  logic line_s = 1'b1;
  // Receiver is off while our driver is on; bus bias then reads high
  assign rx_pin = de ? 1'b1 : line_s;
  task automatic send(input logic [8:0] v);
    logic [10:0] f;
    f = {1'b1, v, 1'b0};
    for (int i = 0; i < 11; i++)
    begin
      line_s = f[i];
      repeat (16) @(negedge mclk);
    end
  endtask : send
endmodule : urm_xcvr

/* test_uart_rs485_multidrop_irda_sleep.sv */
// Self-checking bench for the UART special line modes
`timescale 1ns/10ps
module test_uart_rs485_multidrop_irda_sleep;
  logic        mclk = 1'b0, reset_n = 1'b0, special_function_write = 1'b0, rts_request = 1'b0;
  logic        tx_write = 1'b0, rx_ready = 1'b0, interrupt_pending = 1'b0, receiver_enable_set = 1'b0;
  logic        receiver_enable_clear = 1'b0, wake_int_service = 1'b0, sleep_pin = 1'b0;
  logic        rx_fifo_empty = 1'b1, tx_fifo_empty = 1'b1, te_seen = 1'b0;
  logic [7:0]  feature_control_register = 8'h00, setup_hysteresis_register = 8'h00, tx_wdata = 8'h00;
  logic [7:0]  special_function_register = 8'h00, enhanced_function_register = 8'h00;
  logic [7:0]  modem_control_register = 8'h00, interrupt_enable_register = 8'h00;
  logic [7:0]  fifo_control_register = 8'h00, second_stop_character_register = 8'h00, rx_data;
  logic [15:0] divisor = 16'h0001;
  logic [3:0]  modem_status_delta = 4'h0, modem_inputs = 4'h0;
  logic        tx_write_ready, rx_valid, rx_parity_error, tx_pin, rts_pin, tx_empty_event;
  logic        line_status_event, receiver_enabled, wake_int_flag, osc_stopped, rx_pin;
  int          mismatches = 0, n_compared = 0, k, n, ls_cnt = 0;
  wire  [3:1]  wv = {~rts_pin, osc_stopped, ~tx_pin};

  always #(urm_pkg::CLK_PERIOD_NS / 2) mclk = ~mclk;
  always @(posedge mclk) if (line_status_event === 1'b1) ls_cnt <= ls_cnt + 1;
  always @(posedge mclk) if (tx_empty_event === 1'b1) te_seen <= 1'b1;

  urm_line_modes #(.DIVISOR_DEFAULT(16'h0001)) u_dut (.mclk, .reset_n, .feature_control_register,
    .setup_hysteresis_register, .special_function_register, .special_function_write,
    .enhanced_function_register, .modem_control_register, .interrupt_enable_register, .fifo_control_register,
    .second_stop_character_register, .divisor, .rts_request, .tx_wdata, .tx_write, .tx_write_ready,
    .rx_valid, .rx_data, .rx_parity_error, .rx_ready, .rx_fifo_empty, .tx_fifo_empty, .interrupt_pending,
    .modem_status_delta, .modem_inputs, .receiver_enable_set, .receiver_enable_clear, .wake_int_service,
    .sleep_pin, .rx_pin, .tx_pin, .rts_pin, .tx_empty_event, .line_status_event, .receiver_enabled,
    .wake_int_flag, .osc_stopped);
  urm_xcvr u_xc (.mclk, .de(rts_pin), .rx_pin);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : close_out
  task automatic cmp(input logic [11:0] got, input logic [11:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic cyc(input int c);
    repeat (c) @(negedge mclk);
  endtask : cyc
  // Bounded wait for one watched condition; k holds the cycles spent
  task automatic wt(input int b);
    for (k = 0; k < 4000 && wv[b] !== 1'b1; k++) cyc(1);
    if (wv[b] !== 1'b1)
    begin
      mismatches++;
      close_out();
    end
  endtask : wt
  // Samples one frame at mid-bit: 8 data bits, ninth bit, stop
  task automatic frame(output logic [9:0] f);
    wt(1);
    cyc(8);
    for (int i = 0; i < 10; i++)
    begin
      cyc(16);
      f[i] = tx_pin;
    end
  endtask : frame
  task automatic rx_chk(input logic [8:0] v, input logic st);
    int c0;
    c0 = ls_cnt;
    u_xc.send(v);
    cmp({ls_cnt != c0, rx_valid, rx_parity_error & rx_valid, rx_data & {8{rx_valid}}},
        {st & v[8], st, st & v[8], st ? v[7:0] : 8'h00});
    rx_ready = 1'b1;
    cyc(1);
    rx_ready = 1'b0;
  endtask : rx_chk
  ////////////////////////////////////////////////////////////////////////////////
  task automatic tx_hd();
    logic [9:0] f;
    feature_control_register = 8'h08;
    setup_hysteresis_register = 8'h21;
    special_function_register = 8'h80;
    special_function_write = 1'b1;
    cyc(1);
    special_function_write = 1'b0;
    special_function_register = 8'h00;
    cmp(rts_pin, 1'b0);
    tx_wdata = 8'hA5;
    tx_write = 1'b1;
    cyc(1);
    tx_wdata = 8'h3C;
    for (n = 1; tx_write_ready === 1'b1 && n < 6; n++) cyc(1);
    tx_write = 1'b0;
    cmp({rts_pin, tx_pin, n < 6}, 3'b111);
    frame(f);
    cmp((k + n) inside {[30:36]}, 1'b1);
    cmp(f, {2'b11, 8'hA5});
    for (int i = 1; i < n; i++)
    begin
      frame(f);
      cmp(f, {2'b10, 8'h3C});
    end
    cmp({rts_pin, te_seen}, 2'b10);
    wt(3);
    cmp({k inside {[20:28]}, te_seen}, 2'b11);
    feature_control_register = 8'h00;
  endtask : tx_hd
  task automatic ren_ctl(input logic on);
    receiver_enable_set = on;
    receiver_enable_clear = !on;
    cyc(1);
    receiver_enable_set = 1'b0;
    receiver_enable_clear = 1'b0;
    cmp(receiver_enabled, on);
  endtask : ren_ctl
  // Three zero bits (start, bit 0, ninth) each give one pulse
  task automatic ir_tx(input logic [7:0] sf, input int w);
    special_function_register = sf;
    modem_control_register = 8'h40;
    tx_wdata = 8'hFE;
    tx_write = 1'b1;
    cyc(1);
    tx_write = 1'b0;
    n = 0;
    repeat (200)
    begin
      cyc(1);
      n += int'(tx_pin === 1'b1);
    end
    cmp(n, 3 * w);
  endtask : ir_tx
  task automatic md_norm();
    enhanced_function_register = 8'h10;
    special_function_register = 8'h40;
    rx_chk(9'h055, 1'b0);
    rx_chk(9'h112, 1'b1);
    ren_ctl(1'b1);
    rx_chk(9'h077, 1'b1);
    ren_ctl(1'b0);
    rx_chk(9'h078, 1'b0);
    ren_ctl(1'b1);
    rx_chk(9'h113, 1'b1);
  endtask : md_norm
  task automatic md_auto();
    enhanced_function_register = 8'h30;
    second_stop_character_register = 8'h42;
    rx_chk(9'h141, 1'b0);
    cmp(receiver_enabled, 1'b0);
    rx_chk(9'h099, 1'b0);
    rx_chk(9'h142, 1'b1);
    cmp(receiver_enabled, 1'b1);
    rx_chk(9'h05A, 1'b1);
    rx_chk(9'h142, 1'b1);
    special_function_register = 8'h00;
  endtask : md_auto
  task automatic sleep_reg();
    rts_request = 1'b1;
    fifo_control_register = 8'h08;
    interrupt_pending = 1'b1;
    interrupt_enable_register = 8'h10;
    cyc(40);
    cmp({rts_pin, osc_stopped}, 2'b10);
    interrupt_pending = 1'b0;
    wt(2);
    tx_write = 1'b1;
    cyc(1);
    tx_write = 1'b0;
    cyc(3);
    cmp({osc_stopped, wake_int_flag}, 2'b01);
    cyc(20);
    cmp(wake_int_flag, 1'b1);
    wake_int_service = 1'b1;
    cyc(1);
    wake_int_service = 1'b0;
    cmp(wake_int_flag, 1'b0);
    wt(2);
    interrupt_enable_register = 8'h00;
    cyc(3);
    cmp(osc_stopped, 1'b0);
    sleep_pin = 1'b1;
    wt(2);
    modem_inputs = 4'hF;
    cyc(20);
    cmp(osc_stopped, 1'b1);
    sleep_pin = 1'b0;
    cyc(3);
    cmp(osc_stopped, 1'b0);
  endtask : sleep_reg
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    cyc(3);
    reset_n = 1'b1;
    cyc(1);
    tx_hd();
    md_norm();
    md_auto();
    sleep_reg();
    ir_tx(8'h00, urm_pkg::IR_SLOW_SAMPLES);
    ir_tx(8'h08, urm_pkg::IR_FAST_SAMPLES);
    close_out();
  end
endmodule : test_uart_rs485_multidrop_irda_sleep
